// [rtl/lds_sequencer.sv]
// Summary of operation
// (RULE_01) host starts listen by setting listen enable while in standby
// (RULE_02) idle phase keeps only the rc oscillator running, all else off
// (RULE_03) receiver wakes periodically and stays on once a wanted signal appears
// (RULE_04) no wanted signal by window end turns receiver off until next period
// (RULE_05) receive window counts from the start of receiver wake-up
// (RULE_06) each phase lasts its coefficient times its resolution step
// (RULE_07) step chosen separately for window and idle: 64 us, 4.1 ms, 262 ms
// (RULE_08) coefficient is an integer 1 to 255 multiplying the step
// (RULE_09) step code 01 fine, 10 middle, 11 coarse
// (RULE_10) criterion 0 needs signal level only, 1 also needs sync hit
// (RULE_11) end action 00 stays in receive and stops sequencing
// (RULE_12) end action 01 waits payload or timeout, then goes to mode field
// (RULE_13) end action 10 waits payload or timeout, resumes idle, flushes at wake
// (RULE_14) host ends listen by clearing listen enable
// (RULE_15) rc oscillator calibrates itself after power-up
// (RULE_16) calibration request runs calibration, then sets the done flag
// (RULE_17) automatic mode enters interim state on entry trigger, leaves on leave trigger
// (RULE_18) start and end state of automatic mode follow the mode field
// (RULE_19) continuous data presents each received bit live on the serial pin
// (RULE_20) packet data runs the packet engine, leaving only payload in buffer
// (RULE_21) mode field: 000 sleep, 001 standby, 010 synthesizer, 100 receive
// (RULE_22) wake to receive passes standby, synthesizer, then receive after lock
// (RULE_23) listen timers are reloaded per phase and count resolution steps
`timescale 1ns/1ps
`default_nettype none
module lds_sequencer #(
	parameter int TICK_CYCLES = lds_pkg::STEP_BASE_CYCLES
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// register port
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	// receiver status
	input  wire logic       pll_lock,
	input  wire logic       signal_above_threshold,
	input  wire logic       sync_addr_hit,
	input  wire logic       payload_complete,
	input  wire logic       rx_timeout,
	input  wire logic       checksum_pass,
	input  wire logic       buffer_has_data,
	input  wire logic       demod_bit,
	// block enables and data path
	output logic            rc_osc_on,
	output logic            xo_on,
	output logic            synth_on,
	output logic            rx_on,
	output logic            buffer_flush,
	output logic            packet_engine_en,
	output logic            serial_bit_output,
	output logic [2:0]      current_mode
);
	logic [7:0]         operating_mode_register;
	logic [7:0]         listen_config_one;
	logic [7:0]         idle_coef;
	logic [7:0]         rx_coef;
	logic [7:0]         automatic_mode_config;
	logic [7:0]         interim_config;
	lds_pkg::lds_state_t state;
	lds_pkg::lds_state_t next_state;
	logic [2:0]         next_mode;
	logic               listen_halted;
	logic               cal_busy;
	logic               rc_calibration_complete;
	logic [15:0]        cal_cnt;
	logic [15:0]        tick_cnt;
	logic               tick;
	logic               tmr_load;
	logic               tmr_expired;
	logic               buf_prev;
	logic               cal_request;

	// decoded fields
	logic [2:0] mode_field;
	logic       listen_enable;
	logic [1:0] rx_step;
	logic [1:0] idle_step;
	logic       acceptance_criterion;
	logic [1:0] end_of_cycle_action;
	logic [2:0] interim_entry_trigger;
	logic [2:0] interim_leave_trigger;
	logic [2:0] interim_state;
	logic       packet_mode;
	logic       accept;
	logic       auto_en;
	logic       run_listen;

	assign mode_field            = operating_mode_register[lds_pkg::OPM_MODE_LSB +: 3]; // RULE_21
	assign listen_enable         = operating_mode_register[lds_pkg::OPM_LISTEN_BIT];
	assign rx_step               = listen_config_one[lds_pkg::LC1_RX_STEP_LSB +: 2]; // RULE_07
	assign idle_step             = listen_config_one[lds_pkg::LC1_IDLE_STEP_LSB +: 2];
	assign acceptance_criterion  = listen_config_one[lds_pkg::LC1_CRIT_BIT];
	assign end_of_cycle_action   = listen_config_one[lds_pkg::LC1_END_LSB +: 2];
	assign interim_entry_trigger = automatic_mode_config[lds_pkg::AUTO_ENTRY_LSB +: 3];
	assign interim_leave_trigger = automatic_mode_config[lds_pkg::AUTO_LEAVE_LSB +: 3];
	assign interim_state         = interim_config[lds_pkg::INT_MODE_LSB +: 3];
	assign packet_mode           = interim_config[lds_pkg::INT_PACKET_BIT];
	assign cal_request           = reg_wr && reg_addr == lds_pkg::ADDR_OSC && reg_wdata[lds_pkg::OSC_CAL_REQ_BIT];
	// level alone, or level plus sync hit when the criterion bit is set
	assign accept    = signal_above_threshold && (!acceptance_criterion || sync_addr_hit); // RULE_10
	// one trigger alone would strand the device in the interim state
	assign auto_en   = interim_entry_trigger != lds_pkg::TRIG_NONE
		&& interim_leave_trigger != lds_pkg::TRIG_NONE; // RULE_17
	assign run_listen = listen_enable && !listen_halted;

	// trigger code to event
	function automatic logic lds_trig_hit(input logic [2:0] code, input logic chk, input logic pay,
		input logic syn, input logic bfall, input logic tmo);
		case (code)
			lds_pkg::TRIG_CHECKSUM: lds_trig_hit = chk;
			lds_pkg::TRIG_PAYLOAD:  lds_trig_hit = pay;
			lds_pkg::TRIG_SYNC:     lds_trig_hit = syn;
			lds_pkg::TRIG_BUF_FALL: lds_trig_hit = bfall;
			lds_pkg::TRIG_TIMEOUT:  lds_trig_hit = tmo;
			default:                lds_trig_hit = 1'b0;
		endcase
	endfunction

	// software writes; the calibration request bit is a strobe and is not stored
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			operating_mode_register <= lds_pkg::OPMODE_RST;
			listen_config_one       <= lds_pkg::LCFG_ONE_RST;
			idle_coef               <= lds_pkg::IDLE_COEF_RST;
			rx_coef                 <= lds_pkg::RX_COEF_RST;
			automatic_mode_config   <= lds_pkg::AUTO_RST;
			interim_config          <= lds_pkg::INTERIM_RST;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				lds_pkg::ADDR_OPMODE:    operating_mode_register <= reg_wdata;
				lds_pkg::ADDR_LCFG_ONE:  listen_config_one       <= reg_wdata;
				lds_pkg::ADDR_IDLE_COEF: idle_coef               <= reg_wdata;
				lds_pkg::ADDR_RX_COEF:   rx_coef                 <= reg_wdata;
				lds_pkg::ADDR_AUTO:      automatic_mode_config   <= reg_wdata;
				lds_pkg::ADDR_INTERIM:   interim_config          <= reg_wdata;
				default:                 ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				lds_pkg::ADDR_OPMODE:    reg_rdata <= operating_mode_register;
				lds_pkg::ADDR_LCFG_ONE:  reg_rdata <= listen_config_one;
				lds_pkg::ADDR_IDLE_COEF: reg_rdata <= idle_coef;
				lds_pkg::ADDR_RX_COEF:   reg_rdata <= rx_coef;
				lds_pkg::ADDR_OSC:       reg_rdata <= {1'b0, rc_calibration_complete, 6'h00};
				lds_pkg::ADDR_AUTO:      reg_rdata <= automatic_mode_config;
				lds_pkg::ADDR_INTERIM:   reg_rdata <= interim_config;
				lds_pkg::ADDR_STATUS:    reg_rdata <= {cal_busy, listen_halted, state, current_mode};
				default:                 reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// rc oscillator stand-in: one base tick every 64 us, held off while calibrating
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end
		else if (cal_busy || tick_cnt == 16'(TICK_CYCLES - 1))
		begin
			tick_cnt <= 16'h0000;
			tick     <= !cal_busy;
		end
		else
		begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// calibration runs from reset release and again on request; a request restarts it
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cal_busy                <= 1'b1; // RULE_15
			cal_cnt                 <= 16'(lds_pkg::CAL_CYCLES - 1);
			rc_calibration_complete <= 1'b0;
		end
		else if (cal_request)
		begin
			cal_busy                <= 1'b1; // RULE_16
			cal_cnt                 <= 16'(lds_pkg::CAL_CYCLES - 1);
			rc_calibration_complete <= 1'b0;
		end
		else if (cal_busy)
		begin
			cal_cnt <= cal_cnt - 16'h0001;
			if (cal_cnt == 16'h0000)
			begin
				cal_busy                <= 1'b0;
				rc_calibration_complete <= 1'b1; // RULE_16
			end
		end
	end

	// end actions 00 and 01 stop sequencing until software clears listen enable
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			listen_halted <= 1'b0;
		else if (!listen_enable)
			listen_halted <= 1'b0; // RULE_14
		else if (state == lds_pkg::ST_RX_WIN && accept && end_of_cycle_action == lds_pkg::END_STAY)
			listen_halted <= 1'b1; // RULE_11
		else if (state == lds_pkg::ST_RX_HOLD && end_of_cycle_action == lds_pkg::END_MODE
			&& (payload_complete || rx_timeout))
			listen_halted <= 1'b1; // RULE_12
	end

	// next phase of the sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			lds_pkg::ST_MANUAL:
				if (run_listen && !cal_busy)
					next_state = lds_pkg::ST_IDLE; // RULE_01
				else if (auto_en && lds_trig_hit(interim_entry_trigger, checksum_pass, payload_complete,
					sync_addr_hit, buf_prev && !buffer_has_data, rx_timeout))
					next_state = lds_pkg::ST_INTERIM; // RULE_17
			lds_pkg::ST_IDLE:
				if (!run_listen)
					next_state = lds_pkg::ST_MANUAL;
				else if (tmr_expired)
					next_state = lds_pkg::ST_WAKE_STBY; // RULE_03
			lds_pkg::ST_WAKE_STBY:
				if (!run_listen)
					next_state = lds_pkg::ST_MANUAL;
				else
					next_state = lds_pkg::ST_WAKE_FS; // RULE_22
			lds_pkg::ST_WAKE_FS:
				if (!run_listen)
					next_state = lds_pkg::ST_MANUAL;
				else if (tmr_expired)
					next_state = lds_pkg::ST_IDLE; // RULE_05
				else if (pll_lock)
					next_state = lds_pkg::ST_RX_WIN; // RULE_22
			lds_pkg::ST_RX_WIN:
				if (!run_listen)
					next_state = lds_pkg::ST_MANUAL;
				else if (accept)
					next_state = lds_pkg::ST_RX_HOLD; // RULE_03
				else if (tmr_expired)
					next_state = lds_pkg::ST_IDLE; // RULE_04
			lds_pkg::ST_RX_HOLD:
				if (!listen_enable)
					next_state = lds_pkg::ST_MANUAL; // RULE_14
				else if (end_of_cycle_action != lds_pkg::END_STAY && (payload_complete || rx_timeout))
					next_state = end_of_cycle_action == lds_pkg::END_RESUME
						? lds_pkg::ST_IDLE : lds_pkg::ST_MANUAL; // RULE_12 RULE_13
			lds_pkg::ST_INTERIM:
				if (lds_trig_hit(interim_leave_trigger, checksum_pass, payload_complete,
					sync_addr_hit, buf_prev && !buffer_has_data, rx_timeout) || !auto_en)
					next_state = lds_pkg::ST_MANUAL; // RULE_17 RULE_18
			default:
				next_state = lds_pkg::ST_MANUAL;
		endcase
	end

	// mode applied to the radio for the next phase
	always_comb
	begin
		next_mode = current_mode;
		case (next_state)
			lds_pkg::ST_IDLE:      next_mode = lds_pkg::MODE_SLEEP; // RULE_02
			lds_pkg::ST_WAKE_STBY: next_mode = lds_pkg::MODE_STBY;
			lds_pkg::ST_WAKE_FS:   next_mode = lds_pkg::MODE_FS;
			lds_pkg::ST_RX_WIN:    next_mode = lds_pkg::MODE_RX;
			lds_pkg::ST_RX_HOLD:   next_mode = lds_pkg::MODE_RX;
			lds_pkg::ST_INTERIM:   next_mode = interim_state;
			lds_pkg::ST_MANUAL:
				// a jump to receive steps through standby and synthesizer, waiting on lock
				if (mode_field != lds_pkg::MODE_RX || current_mode == lds_pkg::MODE_RX)
					next_mode = mode_field; // RULE_18 RULE_21
				else if (current_mode == lds_pkg::MODE_FS)
					next_mode = pll_lock ? lds_pkg::MODE_RX : lds_pkg::MODE_FS; // RULE_22
				else if (current_mode == lds_pkg::MODE_STBY)
					next_mode = lds_pkg::MODE_FS;
				else
					next_mode = lds_pkg::MODE_STBY;
			default:               next_mode = mode_field;
		endcase
	end

	// one timer serves both phases, reloaded as each phase begins
	assign tmr_load = next_state != state
		&& (next_state == lds_pkg::ST_IDLE || next_state == lds_pkg::ST_WAKE_STBY); // RULE_05 RULE_23

	lds_listen_timer u_timer (
		.core_clk (core_clk),
		.resetn   (resetn),
		.load     (tmr_load),
		.tick     (tick),
		.coef     (next_state == lds_pkg::ST_IDLE ? idle_coef : rx_coef),
		.step_sel (next_state == lds_pkg::ST_IDLE ? idle_step : rx_step),
		.expired  (tmr_expired)
	);

	// state, applied mode and buffer edge history
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state        <= lds_pkg::ST_MANUAL;
			current_mode <= lds_pkg::MODE_STBY;
			buf_prev     <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			current_mode <= next_mode;
			buf_prev     <= buffer_has_data;
		end
	end

	// block enables follow the applied mode; the rc oscillator never stops
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rc_osc_on <= 1'b0;
			xo_on     <= 1'b0;
			synth_on  <= 1'b0;
			rx_on     <= 1'b0;
		end
		else
		begin
			rc_osc_on <= 1'b1; // RULE_02
			xo_on     <= next_mode != lds_pkg::MODE_SLEEP;
			synth_on  <= next_mode == lds_pkg::MODE_FS || next_mode == lds_pkg::MODE_RX;
			rx_on     <= next_mode == lds_pkg::MODE_RX;
		end
	end

	// stale payload from an earlier window is dropped as the receiver wakes again
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			buffer_flush <= 1'b0;
		else
			buffer_flush <= state == lds_pkg::ST_IDLE && next_state == lds_pkg::ST_WAKE_STBY; // RULE_13
	end

	// data path selection: live bit in continuous, packet engine in packet data
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			serial_bit_output <= 1'b0;
			packet_engine_en  <= 1'b0;
		end
		else
		begin
			serial_bit_output <= rx_on && !packet_mode && demod_bit; // RULE_19
			packet_engine_en  <= rx_on && packet_mode; // RULE_20
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_wake_entry;
		state == lds_pkg::ST_IDLE ##1 state == lds_pkg::ST_WAKE_STBY;
	endsequence
	sequence s_lock_step;
		state == lds_pkg::ST_WAKE_FS && pll_lock && run_listen && !tmr_expired;
	endsequence

	idle_blocks_off_a: assert property (state == lds_pkg::ST_IDLE |-> !xo_on && !synth_on && !rx_on) // RULE_02
		else $error("blocks powered during idle");
	wake_flush_a: assert property (s_wake_entry |-> buffer_flush) // RULE_13
		else $error("no flush at receive wake-up");
	wake_window_a: assert property (s_wake_entry |-> $past(tmr_load)) // RULE_05
		else $error("window timer not loaded at wake-up");
	lock_then_rx_a: assert property (s_lock_step |=> state == lds_pkg::ST_RX_WIN ##0 rx_on) // RULE_22
		else $error("receive not entered after lock");
	window_expiry_a: assert property (state == lds_pkg::ST_RX_WIN && run_listen && !accept && tmr_expired
		|=> state == lds_pkg::ST_IDLE ##1 !rx_on) // RULE_04
		else $error("receiver left on after window");
	criterion_gate_a: assert property (state == lds_pkg::ST_RX_WIN && acceptance_criterion && !sync_addr_hit
		|=> state != lds_pkg::ST_RX_HOLD) // RULE_10
		else $error("accepted without sync hit");
	resume_idle_a: assert property (state == lds_pkg::ST_RX_HOLD && listen_enable && payload_complete
		&& end_of_cycle_action == lds_pkg::END_RESUME |=> state == lds_pkg::ST_IDLE) // RULE_13
		else $error("no return to idle after payload");
	cal_done_a: assert property (cal_request |=> !rc_calibration_complete ##[249:251] rc_calibration_complete
		or ##[1:250] cal_request) // RULE_16
		else $error("calibration done flag late or early");
	serial_live_a: assert property (rx_on && !packet_mode |=> serial_bit_output == $past(demod_bit)) // RULE_19
		else $error("serial bit not live");
endmodule
`default_nettype wire

// [rtl/lds_pkg.sv]
`default_nettype none
package lds_pkg;
	// register offsets
	localparam logic [3:0] ADDR_OPMODE    = 4'h0;
	localparam logic [3:0] ADDR_LCFG_ONE  = 4'h1;
	localparam logic [3:0] ADDR_IDLE_COEF = 4'h2;
	localparam logic [3:0] ADDR_RX_COEF   = 4'h3;
	localparam logic [3:0] ADDR_OSC       = 4'h4;
	localparam logic [3:0] ADDR_AUTO      = 4'h5;
	localparam logic [3:0] ADDR_INTERIM   = 4'h6;
	localparam logic [3:0] ADDR_STATUS    = 4'h7;

	// field positions
	localparam int OPM_MODE_LSB     = 0;
	localparam int OPM_LISTEN_BIT   = 6;
	localparam int LC1_RX_STEP_LSB  = 6;
	localparam int LC1_IDLE_STEP_LSB = 4;
	localparam int LC1_CRIT_BIT     = 3;
	localparam int LC1_END_LSB      = 1;
	localparam int OSC_CAL_REQ_BIT  = 7;
	localparam int OSC_CAL_DONE_BIT = 6;
	localparam int AUTO_ENTRY_LSB   = 5;
	localparam int AUTO_LEAVE_LSB   = 2;
	localparam int INT_MODE_LSB     = 0;
	localparam int INT_PACKET_BIT   = 7;

	// reset values
	localparam logic [7:0] OPMODE_RST    = 8'h01;
	localparam logic [7:0] LCFG_ONE_RST  = 8'h62;
	localparam logic [7:0] IDLE_COEF_RST = 8'hf5;
	localparam logic [7:0] RX_COEF_RST   = 8'h20;
	localparam logic [7:0] AUTO_RST      = 8'h00;
	localparam logic [7:0] INTERIM_RST   = 8'h80;

	// operating mode field encodings
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_STBY  = 3'h1;
	localparam logic [2:0] MODE_FS    = 3'h2;
	localparam logic [2:0] MODE_RX    = 3'h4;

	// end of cycle actions
	localparam logic [1:0] END_STAY   = 2'h0;
	localparam logic [1:0] END_MODE   = 2'h1;
	localparam logic [1:0] END_RESUME = 2'h2;

	// automatic mode triggers, 0 disables
	localparam logic [2:0] TRIG_NONE     = 3'h0;
	localparam logic [2:0] TRIG_CHECKSUM = 3'h1;
	localparam logic [2:0] TRIG_PAYLOAD  = 3'h2;
	localparam logic [2:0] TRIG_SYNC     = 3'h3;
	localparam logic [2:0] TRIG_BUF_FALL = 3'h4;
	localparam logic [2:0] TRIG_TIMEOUT  = 3'h5;

	// resolution step codes and their multiple of the 64 us base tick
	localparam logic [1:0] STEP_FINE   = 2'h1;
	localparam logic [1:0] STEP_MID    = 2'h2;
	localparam logic [1:0] STEP_COARSE = 2'h3;
	localparam logic [12:0] MULT_FINE   = 13'h0001;
	localparam logic [12:0] MULT_MID    = 13'h0040;
	localparam logic [12:0] MULT_COARSE = 13'h1000;

	// timing
	localparam int CLK_PERIOD_NS    = 8;
	localparam int STEP_BASE_NS     = 64000;
	localparam int STEP_BASE_CYCLES = STEP_BASE_NS / CLK_PERIOD_NS;
	localparam int CAL_TIME_NS      = 2000;
	localparam int CAL_CYCLES       = CAL_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_MANUAL    = 3'b000,
		ST_IDLE      = 3'b001,
		ST_WAKE_STBY = 3'b010,
		ST_WAKE_FS   = 3'b011,
		ST_RX_WIN    = 3'b100,
		ST_RX_HOLD   = 3'b101,
		ST_INTERIM   = 3'b110
	} lds_state_t;
endpackage
`default_nettype wire

// [rtl/lds_listen_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module lds_listen_timer (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       resetn,
	// control
	input  wire logic       load,
	input  wire logic       tick,
	input  wire logic [7:0] coef,
	input  wire logic [1:0] step_sel,
	// result
	output logic            expired
);
	logic [20:0] cnt;

	// step code to multiple of the base tick; an unused code acts as the finest step
	function automatic logic [12:0] lds_step_mult(input logic [1:0] sel);
		case (sel)
			lds_pkg::STEP_MID:    lds_step_mult = lds_pkg::MULT_MID; // RULE_09
			lds_pkg::STEP_COARSE: lds_step_mult = lds_pkg::MULT_COARSE; // RULE_09
			default:              lds_step_mult = lds_pkg::MULT_FINE;
		endcase
	endfunction

	// reload at each phase start, count base ticks down, pulse on the last one
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt     <= 21'h000000;
			expired <= 1'b0;
		end
		else if (load)
		begin
			// a zero coefficient is outside range, treated as one
			cnt     <= 21'((coef == 8'h00 ? 8'h01 : coef) * lds_step_mult(step_sel)); // RULE_06 RULE_08 RULE_23
			expired <= 1'b0;
		end
		else
		begin
			expired <= tick && (cnt == 21'h000001); // RULE_23
			if (tick && cnt != 21'h000000)
				cnt <= cnt - 21'h000001;
		end
	end
endmodule
`default_nettype wire

// [tb/lds_radio_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lds_radio_model #(
	parameter int LOCK_CYCLES = 8
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic resetn,
	// synthesizer enable and lock report
	input  wire logic synth_on,
	output logic      pll_lock
);
	int cnt;

	// lock only after a settle time, so a sequencer that skips the wait is seen
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt      <= 0;
			pll_lock <= 1'b0;
		end
		else
		begin
			cnt      <= synth_on ? ((cnt < LOCK_CYCLES) ? cnt + 1 : cnt) : 0;
			pll_lock <= synth_on && (cnt >= LOCK_CYCLES - 1);
		end
	end
endmodule
`default_nettype wire

// [tb/lds_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module lds_sequencer_test;
	logic        core_clk, resetn, reg_wr, reg_rd, sig, syn, pay, tmo, crc, buf_d, dbit;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, v;
	logic        rc_osc_on, xo_on, synth_on, rx_on, flush, pe_en, sbit, pll_lock, rd_pend;
	logic [2:0]  current_mode;
	logic [7:0]  exp_q[$], msk_q[$];
	logic [31:0] rs = 32'h0a2ae858;
	int          n_errors, checks, t0, t1;
	wire logic [4:0] obs = {rx_on, flush, synth_on, xo_on, rc_osc_on};

	lds_sequencer #(.TICK_CYCLES(4)) DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pll_lock(pll_lock), .signal_above_threshold(sig), .sync_addr_hit(syn),
		.payload_complete(pay), .rx_timeout(tmo), .checksum_pass(crc), .buffer_has_data(buf_d),
		.demod_bit(dbit), .rc_osc_on(rc_osc_on), .xo_on(xo_on), .synth_on(synth_on), .rx_on(rx_on),
		.buffer_flush(flush), .packet_engine_en(pe_en), .serial_bit_output(sbit),
		.current_mode(current_mode));
	lds_radio_model radio (.core_clk(core_clk), .resetn(resetn), .synth_on(synth_on), .pll_lock(pll_lock));

	// free-running 125 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	// expected value is noted when the read is issued, compared when data stands
	task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m);
		@(posedge core_clk);
		exp_q.push_back(e);
		msk_q.push_back(m);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
	endtask

	// bounded wait on one enable; running out ends the run as a failure
	task automatic wt(int i, logic e, int lim);
		int k;
		k = 0;
		// step off the edge so the first look sees settled outputs
		#1;
		while (k < lim && obs[i] !== e)
		begin
			cyc(1);
			k++;
		end
		checks++;
		if (k == lim)
		begin
			n_errors++;
			$display("mismatch wait %0d expected %b seen %b", i, e, obs[i]);
			complete_run();
		end
	endtask

	// read data stands only in the cycle after the strobe, so look mid-cycle there
	always @(posedge core_clk) rd_pend <= reg_rd;
	always @(negedge core_clk)
		if (rd_pend === 1'b1)
			chk("reg_rdata", exp_q.pop_front(), reg_rdata & msk_q.pop_front());

	initial
	begin
		{reg_wr, reg_rd, sig, syn, pay, tmo, crc, buf_d, dbit} = '0;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		resetn    = 1'b0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		cyc(300);
		rd(lds_pkg::ADDR_OPMODE, lds_pkg::OPMODE_RST, 8'hff);
		rd(lds_pkg::ADDR_LCFG_ONE, lds_pkg::LCFG_ONE_RST, 8'hff);
		rd(lds_pkg::ADDR_IDLE_COEF, lds_pkg::IDLE_COEF_RST, 8'hff);
		rd(lds_pkg::ADDR_RX_COEF, lds_pkg::RX_COEF_RST, 8'hff);
		rd(lds_pkg::ADDR_OSC, 8'h40, 8'h40);
		rd(lds_pkg::ADDR_AUTO, lds_pkg::AUTO_RST, 8'hff);
		rd(lds_pkg::ADDR_INTERIM, lds_pkg::INTERIM_RST, 8'hff);
		wr(4'h7, 8'hff);
		rd(lds_pkg::ADDR_STATUS, 8'h01, 8'hff);
		rd(4'h8, 8'h00, 8'hff);
		v = 8'(rnd());
		wr(lds_pkg::ADDR_IDLE_COEF, v);
		rd(lds_pkg::ADDR_IDLE_COEF, v, 8'hff);
		wr(lds_pkg::ADDR_OSC, 8'h80);
		rd(lds_pkg::ADDR_OSC, 8'h00, 8'h40);
		rd(lds_pkg::ADDR_STATUS, 8'h80, 8'h80);
		cyc(260);
		rd(lds_pkg::ADDR_OSC, 8'h40, 8'h40);
		$display("test registers done");
		// listen, level criterion, resume after payload
		wr(lds_pkg::ADDR_IDLE_COEF, 8'h02);
		wr(lds_pkg::ADDR_RX_COEF, 8'h06);
		wr(lds_pkg::ADDR_LCFG_ONE, 8'h54);
		wr(lds_pkg::ADDR_OPMODE, 8'h41);
		wt(1, 1'b0, 5);
		wt(1, 1'b1, 40);
		t0 = int'($time);
		chk("xo_on", 8'h01, xo_on);
		wt(2, 1'b1, 5);
		chk("rx_on", 8'h00, rx_on);
		wt(4, 1'b1, 20);
		wt(4, 1'b0, 30);
		t1 = int'($time);
		chk("window", 8'h01, ((t1 - t0) / 8) inside {[20:26]});
		cyc(1);
		chk("idle enables", 8'h01, {3'h0, obs});
		wt(1, 1'b1, 40);
		chk("flush", 8'h01, flush);
		chk("idle time", 8'h01, ((int'($time) - t1) / 8) inside {[4:10]});
		@(posedge core_clk) sig <= 1'b1;
		wt(4, 1'b1, 40);
		cyc(40);
		chk("rx kept", 8'h01, rx_on);
		@(posedge core_clk) {pay, sig} <= 2'b10;
		@(posedge core_clk) pay <= 1'b0;
		wt(4, 1'b0, 5);
		wt(1, 1'b1, 40);
		wr(lds_pkg::ADDR_OPMODE, 8'h01);
		cyc(2);
		chk("mode", 8'h01, current_mode);
		$display("test resume done");
		// sync criterion, stay in receive
		wr(lds_pkg::ADDR_LCFG_ONE, 8'h58);
		@(posedge core_clk) sig <= 1'b1;
		wr(lds_pkg::ADDR_OPMODE, 8'h41);
		wt(4, 1'b1, 60);
		wt(4, 1'b0, 40);
		@(posedge core_clk) syn <= 1'b1;
		wt(4, 1'b1, 60);
		cyc(40);
		chk("rx stays", 8'h01, rx_on);
		wr(lds_pkg::ADDR_OPMODE, 8'h01);
		cyc(2);
		chk("rx off", 8'h00, rx_on);
		@(posedge core_clk) {syn, sig} <= 2'b00;
		$display("test stay done");
		// go to the mode field after a timeout
		wr(lds_pkg::ADDR_LCFG_ONE, 8'h52);
		wr(lds_pkg::ADDR_OPMODE, 8'h41);
		wr(lds_pkg::ADDR_OPMODE, 8'h42);
		@(posedge core_clk) sig <= 1'b1;
		wt(4, 1'b1, 60);
		@(posedge core_clk) {tmo, sig} <= 2'b10;
		@(posedge core_clk) tmo <= 1'b0;
		cyc(6);
		chk("mode", {5'h0, lds_pkg::MODE_FS}, current_mode);
		wr(lds_pkg::ADDR_OPMODE, 8'h01);
		$display("test mode end done");
		// middle idle step: one coefficient unit spans 64 base ticks
		wr(lds_pkg::ADDR_IDLE_COEF, 8'h01);
		wr(lds_pkg::ADDR_LCFG_ONE, 8'h64);
		wr(lds_pkg::ADDR_OPMODE, 8'h41);
		wt(1, 1'b0, 5);
		t1 = int'($time);
		wt(1, 1'b1, 300);
		chk("idle mid", 8'h01, ((int'($time) - t1) / 8) inside {[250:260]});
		wr(lds_pkg::ADDR_OPMODE, 8'h01);
		$display("test step done");
		// automatic modes: checksum in, buffer falling out, mode rewritten meanwhile
		wr(lds_pkg::ADDR_AUTO, 8'h30);
		@(posedge core_clk) {buf_d, crc} <= 2'b11;
		@(posedge core_clk) crc <= 1'b0;
		cyc(3);
		chk("mode", {5'h0, lds_pkg::MODE_SLEEP}, current_mode);
		wr(lds_pkg::ADDR_OPMODE, 8'h02);
		cyc(2);
		chk("mode", {5'h0, lds_pkg::MODE_SLEEP}, current_mode);
		@(posedge core_clk) buf_d <= 1'b0;
		cyc(6);
		chk("mode", {5'h0, lds_pkg::MODE_FS}, current_mode);
		wr(lds_pkg::ADDR_AUTO, 8'h00);
		$display("test auto done");
		// every mode code, ending in receive
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 3) ? 8'h04 : 8'(i);
			wr(lds_pkg::ADDR_OPMODE, v);
			cyc(20);
			chk("mode", v, current_mode);
			chk("synth_on", 8'(v >= 8'h02), synth_on);
			chk("rx_on", 8'(v == 8'h04), rx_on);
		end
		chk("packet", 8'h01, pe_en);
		wr(lds_pkg::ADDR_INTERIM, 8'h00);
		cyc(2);
		chk("packet", 8'h00, pe_en);
		for (int i = 0; i < 16; i++)
		begin
			v = 8'(rnd());
			@(posedge core_clk) dbit <= v[0];
			cyc(1);
			chk("serial bit", {7'h0, v[0]}, sbit);
		end
		$display("test data done");
		complete_run();
	end
endmodule
`default_nettype wire
